// ===== rtl/sdg_cfg.svh
// Constants for the system descriptor and gate decoder
//
// Contract
// - 32-bit base/20-bit limit, legacy 24/16
// - Upper 16 bits zero marks legacy descriptor
// - System type 2 is local table; privilege ignored
// - Local-table descriptors only from global table
// - Task-state types are 1, 3, 9, B
// - Gate types 4,5,6,7,C,E,F decoded
// - Call-gate count used only on privilege change
// - Count 0-31 of 32-bit or 16-bit items
// - Interrupt gate clears interrupt enable; trap keeps
// - Task gate uses selector only, offset ignored
// - Wrong target type raises exception 13
// - Gate not present raises exception 11
// - Access bit 4 must be zero
// - Gate privilege is least privileged caller level
// - Offset is entry point, 16 or 32 bits
// - Call-gate pushes 16 or 32 by stack flag
// - Table indicator picks global or local table
// - Index picks one of 8K descriptors
// - Segment load fetches 8-byte descriptor into cache
// - References served from cache until reload
// - Cache contents never readable by software
// - Requester privilege is selector bits 1-0
// - Granular limit scales by 4K pages
`ifndef SDG_CFG_SVH
`define SDG_CFG_SVH
`define SDG_A_CMD       8'h00
`define SDG_A_GTBASE    8'h04
`define SDG_A_CTRL      8'h08
`define SDG_A_STATUS    8'h0c
`define SDG_A_GSEL      8'h10
`define SDG_A_GOFF      8'h14
`define SDG_A_GINFO     8'h18
`define SDG_SLOT_LTAB   3'h6
`define SDG_SLOT_TASK   3'h7
`define SDG_T_LTAB      4'h2
`define SDG_T_TASK_GATE 4'h5
`define SDG_EXC_NP      8'h0b
`define SDG_EXC_GP      8'h0d
`define SDG_RST_WORD    32'h0000_0000
`endif

// ===== rtl/sdg_pkg.sv
// Types for the system descriptor and gate decoder
package sdg_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RD0, ST_RD1, ST_CHK, ST_TCHK} fsm_t;
    typedef struct packed {
        logic [12:0] index;
        logic        ti;
        logic [1:0]  requester_privilege;
    } sel_t;
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic        present;
        logic [1:0]  descriptor_privilege;
        logic        code_data;
        logic [3:0]  typ;
        logic        legacy;
    } desc_t;
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0]  attr;
    } cache_t;
    typedef struct packed {
        logic [1:0] cpl;
        logic       priv_change;
        logic       stack_32;
    } ctrl_t;
    typedef struct packed {
        logic [4:0] count;
        logic [6:0] bytes;
        logic       if_clear;
        logic       push_32;
        logic [1:0] descriptor_privilege;
        logic       task_gate;
    } ginfo_t;
    typedef struct packed {
        fsm_t         st;
        sel_t         sel;
        logic [2:0]   slot;
        logic         gate_op;
        logic         tgt;
        logic [3:0]   gtyp;
        logic [31:0]  w0;
        logic [31:0]  w1;
        logic [31:0]  mem_addr;
        logic [31:0]  gt_base;
        ctrl_t        ctrl;
        logic         done;
        logic         fault;
        logic [7:0]   vec;
        logic         legacy;
        logic [3:0]   typ;
        logic [15:0]  gate_sel;
        logic [31:0]  gate_off;
        ginfo_t       ginfo;
        logic [31:0]  prdata;
        cache_t [7:0] cache;
        cache_t       ref_out;
    } state_t;
endpackage : sdg_pkg

// ===== rtl/system_descriptor_gate_decoder.sv
// Descriptor fetch, gate decode and segment descriptor cache
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sdg_cfg.svh"

module system_descriptor_gate_decoder
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic [2:0]  ref_slot,
    output logic [31:0]      ref_base,
    output logic [31:0]      ref_limit,
    output logic [7:0]       ref_attr
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic sdg_pkg::sel_t sel_dec
    (
        input logic [15:0] v
    );
        sdg_pkg::sel_t s;
        s.index = v[15:3];
        s.ti    = v[2];
        s.requester_privilege   = v[1:0];
        return s;
    endfunction : sel_dec

    function automatic logic [31:0] entry_addr
    (
        input logic [31:0]   tbase,
        input sdg_pkg::sel_t s
    );
        return tbase + {16'h0000, s.index, 3'b000};
    endfunction : entry_addr

    function automatic sdg_pkg::desc_t desc_dec
    (
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        sdg_pkg::desc_t d;
        logic [31:0]    lim;
        lim         = 32'h0000_0000;
        d.legacy    = (hi[31:16] == 16'h0000);
        d.present   = hi[15];
        d.descriptor_privilege       = hi[14:13];
        d.code_data = hi[12];
        d.typ       = hi[11:8];
        if (d.legacy)
        begin
            d.base = {8'h00, hi[7:0], lo[31:16]};
            lim    = {16'h0000, lo[15:0]};
        end
        else
        begin
            d.base = {hi[31:24], hi[7:0], lo[31:16]};
            lim    = {12'h000, hi[19:16], lo[15:0]};
        end
        if (!d.legacy && hi[23])
        begin
            d.limit = {lim[19:0], 12'hfff};
        end
        else
        begin
            d.limit = lim;
        end
        return d;
    endfunction : desc_dec

    function automatic logic is_tss
    (
        input logic [3:0] t
    );
        case (t)
            4'h1, 4'h3, 4'h9, 4'hb: return 1'b1;
            default:                return 1'b0;
        endcase
    endfunction : is_tss

    function automatic logic is_gate
    (
        input logic [3:0] t
    );
        case (t)
            4'h4, 4'h5, 4'h6, 4'h7,
            4'hc, 4'he, 4'hf:       return 1'b1;
            default:                return 1'b0;
        endcase
    endfunction : is_gate

    function automatic logic reg_hit
    (
        input logic [7:0] a
    );
        case (a)
            `SDG_A_CMD, `SDG_A_GTBASE, `SDG_A_CTRL, `SDG_A_STATUS,
            `SDG_A_GSEL, `SDG_A_GOFF, `SDG_A_GINFO: return 1'b1;
            default:                                return 1'b0;
        endcase
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // State

    sdg_pkg::state_t s_q;
    sdg_pkg::state_t s_d;
    sdg_pkg::desc_t  dsc;
    sdg_pkg::sel_t   nsel;
    logic            wr_acc;
    logic            rd_setup;
    logic            busy;
    logic            call_gate;
    logic [31:0]     tbase;

    assign busy     = (s_q.st != sdg_pkg::ST_IDLE);
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d       = s_q;
        dsc       = desc_dec(s_q.w0, s_q.w1);
        nsel      = sel_dec(pwdata[15:0]);
        call_gate = (dsc.typ[2:0] == 3'h4);
        tbase     = 32'h0000_0000;

        // Register writes
        if (wr_acc && paddr == `SDG_A_GTBASE)
        begin
            s_d.gt_base = pwdata;
        end
        if (wr_acc && paddr == `SDG_A_CTRL)
        begin
            s_d.ctrl = pwdata[3:0];
        end

        // Read data captured in the setup phase; cache never mapped
        if (rd_setup)
        begin
            case (paddr)
                `SDG_A_CMD:    s_d.prdata = {11'h000, s_q.gate_op, 1'b0,
                                             s_q.slot, s_q.sel};
                `SDG_A_GTBASE: s_d.prdata = s_q.gt_base;
                `SDG_A_CTRL:   s_d.prdata = {28'h0000000, s_q.ctrl};
                `SDG_A_STATUS: s_d.prdata = {6'h00,
                                             s_q.typ[3] & is_tss(s_q.typ),
                                             s_q.typ[1] & is_tss(s_q.typ),
                                             s_q.typ, 3'h0, s_q.legacy,
                                             s_q.vec, 5'h00, s_q.fault,
                                             s_q.done, busy};
                `SDG_A_GSEL:   s_d.prdata = {16'h0000, s_q.gate_sel};
                `SDG_A_GOFF:   s_d.prdata = s_q.gate_off;
                `SDG_A_GINFO:  s_d.prdata = {15'h0000, s_q.ginfo};
                default:       s_d.prdata = `SDG_RST_WORD;
            endcase
        end

        case (s_q.st)
            sdg_pkg::ST_IDLE:
            begin
                if (wr_acc && paddr == `SDG_A_CMD)
                begin
                    s_d.sel     = nsel;
                    s_d.slot    = pwdata[18:16];
                    s_d.gate_op = pwdata[20];
                    s_d.tgt     = 1'b0;
                    s_d.done    = 1'b0;
                    s_d.fault   = 1'b0;
                    s_d.vec     = 8'h00;
                    if (nsel.ti)
                    begin
                        tbase = s_q.cache[`SDG_SLOT_LTAB].base;
                    end
                    else
                    begin
                        tbase = s_q.gt_base;
                    end
                    s_d.mem_addr = entry_addr(tbase, nsel);
                    s_d.st       = sdg_pkg::ST_RD0;
                end
            end

            sdg_pkg::ST_RD0:
            begin
                if (mem_ack)
                begin
                    s_d.w0       = mem_rdata;
                    s_d.mem_addr = s_q.mem_addr + 32'h0000_0004;
                    s_d.st       = sdg_pkg::ST_RD1;
                end
            end

            sdg_pkg::ST_RD1:
            begin
                if (mem_ack)
                begin
                    s_d.w1 = mem_rdata;
                    if (s_q.tgt)
                    begin
                        s_d.st = sdg_pkg::ST_TCHK;
                    end
                    else
                    begin
                        s_d.st = sdg_pkg::ST_CHK;
                    end
                end
            end

            sdg_pkg::ST_CHK:
            begin
                s_d.legacy = dsc.legacy;
                s_d.typ    = dsc.typ;
                s_d.st     = sdg_pkg::ST_IDLE;
                s_d.done   = 1'b1;
                if (s_q.gate_op)
                begin
                    if (dsc.code_data || !is_gate(dsc.typ))
                    begin
                        s_d.fault = 1'b1;
                        s_d.vec   = `SDG_EXC_GP;
                    end
                    else if (!dsc.present)
                    begin
                        s_d.fault = 1'b1;
                        s_d.vec   = `SDG_EXC_NP;
                    end
                    else if (s_q.ctrl.cpl > dsc.descriptor_privilege)
                    begin
                        s_d.fault = 1'b1;
                        s_d.vec   = `SDG_EXC_GP;
                    end
                    else
                    begin
                        s_d.gtyp     = dsc.typ;
                        s_d.gate_sel = s_q.w0[31:16];
                        if (dsc.typ == `SDG_T_TASK_GATE)
                        begin
                            s_d.gate_off = 32'h0000_0000;
                        end
                        else if (dsc.typ[3])
                        begin
                            s_d.gate_off = {s_q.w1[31:16], s_q.w0[15:0]};
                        end
                        else
                        begin
                            s_d.gate_off = {16'h0000, s_q.w0[15:0]};
                        end
                        if (call_gate && s_q.ctrl.priv_change)
                        begin
                            s_d.ginfo.count = s_q.w1[4:0];
                        end
                        else
                        begin
                            s_d.ginfo.count = 5'h00;
                        end
                        if (dsc.typ[3])
                        begin
                            s_d.ginfo.bytes = {s_d.ginfo.count, 2'b00};
                        end
                        else
                        begin
                            s_d.ginfo.bytes = {1'b0, s_d.ginfo.count, 1'b0};
                        end
                        s_d.ginfo.if_clear  = (dsc.typ[2:0] == 3'h6);
                        s_d.ginfo.push_32   = call_gate & s_q.ctrl.stack_32;
                        s_d.ginfo.descriptor_privilege       = dsc.descriptor_privilege;
                        s_d.ginfo.task_gate = (dsc.typ == `SDG_T_TASK_GATE);
                        nsel = sel_dec(s_q.w0[31:16]);
                        if (nsel.ti)
                        begin
                            tbase = s_q.cache[`SDG_SLOT_LTAB].base;
                        end
                        else
                        begin
                            tbase = s_q.gt_base;
                        end
                        s_d.mem_addr = entry_addr(tbase, nsel);
                        s_d.tgt      = 1'b1;
                        s_d.done     = 1'b0;
                        s_d.st       = sdg_pkg::ST_RD0;
                    end
                end
                else
                begin
                    if (s_q.slot == `SDG_SLOT_LTAB)
                    begin
                        // Privilege field of the entry is not checked
                        s_d.fault = dsc.code_data || dsc.typ != `SDG_T_LTAB
                                    || s_q.sel.ti;
                    end
                    else if (s_q.slot == `SDG_SLOT_TASK)
                    begin
                        s_d.fault = dsc.code_data || !is_tss(dsc.typ)
                                    || dsc.typ[1];
                    end
                    else
                    begin
                        s_d.fault = !dsc.code_data;
                    end
                    if (s_d.fault)
                    begin
                        s_d.vec = `SDG_EXC_GP;
                    end
                    else if (!dsc.present)
                    begin
                        s_d.fault = 1'b1;
                        s_d.vec   = `SDG_EXC_NP;
                    end
                    else
                    begin
                        s_d.cache[s_q.slot] = {dsc.base, dsc.limit,
                                               s_q.w1[15:8]};
                    end
                end
            end

            sdg_pkg::ST_TCHK:
            begin
                s_d.st   = sdg_pkg::ST_IDLE;
                s_d.done = 1'b1;
                if (s_q.gtyp == `SDG_T_TASK_GATE)
                begin
                    s_d.fault = dsc.code_data || !is_tss(dsc.typ);
                end
                else
                begin
                    s_d.fault = !dsc.code_data || !dsc.typ[3];
                end
                if (s_d.fault)
                begin
                    s_d.vec = `SDG_EXC_GP;
                end
                else if (!dsc.present)
                begin
                    s_d.fault = 1'b1;
                    s_d.vec   = `SDG_EXC_NP;
                end
            end

            default:
            begin
                s_d.st = sdg_pkg::ST_IDLE;
            end
        endcase

        // Lookups never touch the tables
        s_d.ref_out = s_q.cache[ref_slot];
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata    = s_q.prdata;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~reg_hit(paddr);
    assign mem_req   = (s_q.st == sdg_pkg::ST_RD0) || (s_q.st == sdg_pkg::ST_RD1);
    assign mem_addr  = s_q.mem_addr;
    assign ref_base  = s_q.ref_out.base;
    assign ref_limit = s_q.ref_out.limit;
    assign ref_attr  = s_q.ref_out.attr;

endmodule : system_descriptor_gate_decoder

`default_nettype wire

// ===== tb/sdg_properties.sv
// Port checker for the descriptor decoder
`timescale 1ns/10ps
`default_nettype none
`include "sdg_cfg.svh"
module sdg_properties
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic [2:0]  ref_slot,
    input wire logic [31:0] ref_base,
    input wire logic [31:0] ref_limit,
    input wire logic [7:0]  ref_attr
);
    logic        busy_q;
    logic [31:0] gt_q;
    logic [31:0] exp_q;
    logic [2:0]  idle_q;
    logic        cmd_w;
    logic        acc;
    assign acc = psel && penable;
    assign cmd_w = acc && pwrite && paddr == `SDG_A_CMD;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            gt_q   <= 32'h0;
            exp_q  <= 32'h0;
            idle_q <= 3'h0;
        end
        else
        begin
            if (cmd_w)
                busy_q <= 1'b1;
            else if (acc && !pwrite && paddr == `SDG_A_STATUS && !prdata[0])
                busy_q <= 1'b0;
            if (acc && pwrite && paddr == `SDG_A_GTBASE)
                gt_q <= pwdata;
            if (cmd_w)
                exp_q <= gt_q + {16'h0, pwdata[15:3], 3'h0};
            idle_q <= mem_req ? 3'h0 : (idle_q == 3'h7 ? idle_q : idle_q + 3'h1);
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_first_addr;
        cmd_w && !busy_q && !pwdata[2] |=> mem_req && mem_addr == exp_q;
    endproperty
    a_first_addr: assert property (p_first_addr)
        else $error("first fetch address wrong");
    property p_next_word;
        mem_req && mem_ack && !mem_addr[2] |=> mem_req && mem_addr == $past(mem_addr) + 32'h4;
    endproperty
    a_next_word: assert property (p_next_word)
        else $error("second word not fetched");
    property p_hold_req;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_hold_req: assert property (p_hold_req)
        else $error("fetch request dropped");
    property p_quiet;
        !busy_q |-> !mem_req;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("table read without reload");
    property p_cache_hold;
        idle_q == 3'h7 && $stable(ref_slot)
            |=> $stable(ref_base) && $stable(ref_limit) && $stable(ref_attr);
    endproperty
    a_cache_hold: assert property (p_cache_hold)
        else $error("cache changed without reload");
    property p_slverr;
        acc |-> pready && pslverr == (paddr > `SDG_A_GINFO || paddr[1:0] != 2'h0);
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("bus error flag wrong");
    property p_unmapped_zero;
        acc && !pwrite && paddr > `SDG_A_GINFO |-> prdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    property p_prdata_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold)
        else $error("read data moved");
    c_cmd: cover property (cmd_w);
    c_slow: cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
    c_err: cover property (acc && pslverr);
endmodule : sdg_properties

bind system_descriptor_gate_decoder sdg_properties u_props
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata, .ref_slot, .ref_base, .ref_limit, .ref_attr
);
`default_nettype wire

// ===== tb/desc_table_model.sv
// Descriptor table memory behind the fetch port
`timescale 1ns/10ps
`default_nettype none
module desc_table_model
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        slow,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    output logic            mem_ack,
    output logic [31:0]     mem_rdata
);
    logic [31:0] words [0:63];
    logic [1:0]  wait_q;
    initial
        foreach (words[i])
            words[i] = 32'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_q    <= 2'h0;
        end
        else if (mem_req && !mem_ack && (!slow || wait_q == 2'h3))
        begin
            mem_ack   <= 1'b1;
            mem_rdata <= words[mem_addr[7:2]];
            wait_q    <= 2'h0;
        end
        else
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q    <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : desc_table_model
`default_nettype wire

// ===== tb/system_descriptor_gate_decoder_tb.sv
// Self-checking bench for the descriptor decoder
`timescale 1ns/10ps
`default_nettype none
`include "sdg_cfg.svh"
module system_descriptor_gate_decoder_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  ref_slot = 3'h0;
    logic        slow = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    logic [31:0] ref_base;
    logic [31:0] ref_limit;
    logic [7:0]  ref_attr;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] rd;
    logic        er;
    logic [31:0] st;
    logic [31:0] f;
    logic [15:0] sel;
    logic [4:0]  cnt;
    logic [3:0]  t;
    logic        lg;
    logic        cl;
    logic        pv;
    logic [3:0]  task_state_segment [4] = '{4'h1, 4'h9, 4'h3, 4'hb};
    logic [3:0]  gty [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    logic [31:0] flt [5] = '{32'h6c28_000b, 32'hfc28_000d, 32'he528_000d,
                             32'hec30_000d, 32'h8c28_030d};
    always #25 pclk = ~pclk;
    system_descriptor_gate_decoder DUT
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_req, .mem_addr, .mem_ack, .mem_rdata, .ref_slot, .ref_base, .ref_limit, .ref_attr
    );
    desc_table_model mem_m
    (
        .pclk, .presetn, .slow, .mem_req, .mem_addr, .mem_ack, .mem_rdata
    );
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic bound(input int n, input int lim);
        if (n == lim)
        begin
            error_cnt++;
            complete_run();
        end
    endtask : bound
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        bound(n, 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(input logic [31:0] cmd);
        int n;
        apb(1'b1, `SDG_A_CMD, cmd);
        for (n = 0; n < 30; n++)
        begin
            apb(1'b0, `SDG_A_STATUS, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        bound(n, 30);
        st = rd;
    endtask : op
    task automatic put(input int i, input logic [31:0] w0, input logic [31:0] w1);
        mem_m.words[2 * i] = w0;
        mem_m.words[2 * i + 1] = w1;
    endtask : put
    task automatic refc(input logic [2:0] s, input logic [31:0] b, input logic [31:0] l,
                        input logic [7:0] a);
        ref_slot <= s;
        @(posedge pclk);
        @(negedge pclk);
        chk(ref_base, b);
        chk(ref_limit, l);
        chk({24'h0, ref_attr}, {24'h0, a});
        @(posedge pclk);
    endtask : refc
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        refc(3'h1, 32'h0, 32'h0, 8'h0);
        apb(1'b0, `SDG_A_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `SDG_A_GTBASE, 32'h0);
        // Page granular load over slow memory, then edits without reload
        put(1, 32'h3c4d_5678, 32'h1a83_9a2b);
        slow <= 1'b1;
        op(32'h0001_0008);
        chk(st & 32'h0001_0007, 32'h2);
        refc(3'h1, 32'h1a2b_3c4d, 32'h3567_8fff, 8'h9a);
        put(1, 32'h3c4d_5678, 32'h0000_9a2b);
        refc(3'h1, 32'h1a2b_3c4d, 32'h3567_8fff, 8'h9a);
        slow <= 1'b0;
        op(32'h0001_000b);
        chk(st & 32'h0001_0007, 32'h0001_0002);
        refc(3'h1, 32'h002b_3c4d, 32'h0000_5678, 8'h9a);
        // Local table descriptor, global then local origin
        put(2, 32'h3c00_00ff, 32'h1a00_e22b);
        op(32'h0006_0010);
        chk(st & 32'h7, 32'h2);
        refc(3'h6, 32'h1a2b_3c00, 32'h0000_00ff, 8'he2);
        op(32'h0006_0014);
        chk(st & 32'hff07, 32'h0d06);
        refc(3'h6, 32'h1a2b_3c00, 32'h0000_00ff, 8'he2);
        // Task state types
        foreach (task_state_segment[i])
        begin
            t = task_state_segment[i];
            lg = !t[3];
            put(3, 32'h0000_0067, {lg ? 16'h0 : 16'h0040, 4'h8, t, 8'h0});
            op(32'h0007_0018);
            if (t[1])
                chk(st & 32'h7, 32'h6);
            else
                chk(st & 32'h03f1_0007, {6'h0, t[3], 1'b0, t, 3'h0, lg, 16'h2});
        end
        // Every gate type, with and without privilege change
        put(5, 32'h0000_ffff, 32'h00cf_9a00);
        put(6, 32'h0000_0067, 32'h0040_8900);
        for (int p = 0; p < 2; p++)
            foreach (gty[i])
            begin
                pv = p[0];
                t = gty[i];
                lg = !t[3];
                cl = t[1:0] == 2'h0;
                sel = t == 4'h5 ? 16'h0030 : 16'h0028;
                cnt = (cl && pv) ? 5'h1f : 5'h0;
                put(4, {sel, 16'hbeef}, {lg ? 16'h0 : 16'h1357, 4'he, t, 8'h1f});
                apb(1'b1, `SDG_A_CTRL, {28'h0, 2'h0, pv, !pv});
                op(32'h0010_0020);
                chk(st & 32'h7, 32'h2);
                apb(1'b0, `SDG_A_GSEL, 32'h0);
                chk(rd, {16'h0, sel});
                apb(1'b0, `SDG_A_GOFF, 32'h0);
                f = t == 4'h5 ? 32'h0 : {lg ? 16'h0 : 16'h1357, 16'hbeef};
                chk(rd, f);
                apb(1'b0, `SDG_A_GINFO, 32'h0);
                f = {15'h0, cnt, cnt * (lg ? 7'h2 : 7'h4), t[2:0] == 3'h6, cl && !pv, 2'h3,
                     t == 4'h5};
                chk(rd & (cl ? 32'h1ffff : 32'h1fff7), f);
            end
        // Refused gates
        foreach (flt[i])
        begin
            f = flt[i];
            put(4, {8'h0, f[23:16], 16'hbeef}, {16'h1357, f[31:24], 8'h0});
            apb(1'b1, `SDG_A_CTRL, {28'h0, f[9:8], 2'h0});
            op(32'h0010_0020);
            chk(st & 32'hff07, {16'h0, f[7:0], 8'h06});
        end
        complete_run();
    end
endmodule : system_descriptor_gate_decoder_tb
`default_nettype wire
